/* File: header_builder_consts.vh */
`ifndef HEADER_BUILDER_CONSTS_VH
`define HEADER_BUILDER_CONSTS_VH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_LOCAL_COUNTS 8'h08
`define OFS_GLOBAL_COUNTS 8'h0c
`define OFS_GROUP_ID 8'h10
`define OFS_SCRATCH 8'h14
`define OFS_BINDING 8'h18
`define OFS_SAMPLER 8'h1c
`define OFS_BARRIER_DESC 8'h20
`define OFS_LENGTHS 8'h24
// payload memory window: bus address bit 8 set
`define MEM_WINDOW_BIT 8

// control fields
`define CTL_MODE_LO 0
`define CTL_CONST_EN 4
`define CTL_INLINE_EN 5
`define CTL_SCRATCH_EN 6
`define CTL_BARRIER_EN 8
`define CTL_SEL_LO 16
`define CTL_START 31

// dispatch modes
`define MODE_GENERIC 2'h0
`define MODE_GROUPED 2'h1
`define MODE_WALKER 2'h2

// header dword lanes
`define LANE_GROUP_HIGH 3'h2
`define LANE_SAMPLER 3'h3
`define LANE_BINDING 3'h4
`define LANE_SCRATCH 3'h5
`define LANE_GROUP_LOW 3'h7
`define LANE_LAST 3'h7

// reset values
`define RST_WORD 32'h0000_0000

`endif

/* File: payload_memory.v */
`timescale 1ns/1ns
// one write port, one registered read port
module payload_memory #(
    parameter ADDR_WIDTH = 6,
    parameter DATA_WIDTH = 32
) (
    input wire clk_in,
    input wire write_in,
    input wire [ADDR_WIDTH-1:0] write_addr_in,
    input wire [DATA_WIDTH-1:0] write_data_in,
    input wire [ADDR_WIDTH-1:0] read_addr_in,
    output reg [DATA_WIDTH-1:0] read_data_out
);
    reg [DATA_WIDTH-1:0] store [0:(1<<ADDR_WIDTH)-1];

    always @(posedge clk_in) begin
        if (write_in) begin
            store[write_addr_in] <= write_data_in;
        end
        read_data_out <= store[read_addr_in];
    end
endmodule // payload_memory

/* File: media_thread_header_builder.v */
`timescale 1ns/1ns
`include "header_builder_consts.vh"
// Summary of operation
// - both payload kinds: header row, then constant rows, then inline rows
// - partial inline row padded with zeros; no indirect data block appended
// - low group word in dword 7; grouped command gives full id; selector 0 zero
// - selector 1 low: inner global 6:0, outer local, mid local, inner local
// - selector 2 low: outer global 6:0, inner global, outer local, mid local
// - selector 3 low: two zeros, outer global, inner global, outer local
// - selector 4 low: twelve zeros, outer global, inner global
// - high group bits in dword 2 bits 23:11; zero for grouped or selector 0
// - selector 1 high: outer global 9:0 then inner global 9:7
// - selector 2 high: ten zeros then outer global 9:7; selectors 3-5 zero
// - scratch pointer bits 31:10 in dword 5, valid only with scratch enabled
// - thread slot tag in dword 5 bits 9:0
// - binding table pointer in dword 4 bits 31:5, bits 4:0 zero
// - sampler pointer in dword 3 bits 31:5, bit 4 zero
// - scratch size exponent in dword 3 bits 3:0, range 0 to 11
// - dword 2 bit 31 set when a barrier is allocated
// - barrier number in dword 2 bits 30:24
// - interface descriptor index in dword 2 bits 9:4
// - unused walker loops count as zero
// - counters: inner/outer local 10, mid local 5, inner/outer global 10 bits
module media_thread_header_builder #(
    parameter MEM_ADDR_WIDTH = 6
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [8:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    output reg dword_valid_out,
    output reg [31:0] dword_data_out,
    output reg [7:0] dword_row_out,
    output reg [2:0] dword_lane_out,
    output reg payload_last_out,
    output reg busy_out
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_HEADER = 4'b0010;
    localparam ST_CONST = 4'b0100;
    localparam ST_INLINE = 4'b1000;
    localparam SRC_HEADER = 2'h0;
    localparam SRC_MEM = 2'h1;
    localparam SRC_ZERO = 2'h2;

    // software registers
    reg [31:0] control;
    reg [24:0] local_counts;
    reg [19:0] global_counts;
    reg [31:0] group_id;
    reg [31:0] scratch;
    reg [31:0] binding;
    reg [31:0] sampler;
    reg [13:0] barrier_desc;
    reg [23:0] lengths;
    reg [15:0] payload_count;

    // sequencer
    reg [3:0] state;
    reg [2:0] lane;
    reg [7:0] row;
    reg [7:0] const_rows_done;
    reg [7:0] inline_index;
    reg [MEM_ADDR_WIDTH-1:0] mem_addr;
    reg [3:0] next_state;
    reg [2:0] next_lane;
    reg [7:0] next_row;
    reg [7:0] next_const_rows_done;
    reg [7:0] next_inline_index;
    reg [MEM_ADDR_WIDTH-1:0] next_mem_addr;
    reg emit;
    reg [1:0] emit_src;
    reg emit_last;

    // pipeline stage aligned with the memory read latency
    reg stage_valid;
    reg [1:0] stage_src;
    reg [31:0] stage_header;
    reg [7:0] stage_row;
    reg [2:0] stage_lane;
    reg stage_last;
    wire [31:0] mem_rdata;

    wire [1:0] mode = control[`CTL_MODE_LO+1:`CTL_MODE_LO];
    wire [2:0] loop_sel = control[`CTL_SEL_LO+2:`CTL_SEL_LO];
    wire const_en = control[`CTL_CONST_EN];
    wire inline_en = control[`CTL_INLINE_EN];
    wire [7:0] const_rows = lengths[7:0];
    wire [7:0] inline_dwords = lengths[23:16];
    wire [9:0] inner_local = local_counts[9:0];
    wire [4:0] mid_local = local_counts[14:10];
    wire [9:0] outer_local = local_counts[24:15];
    wire [9:0] inner_global = global_counts[9:0];
    wire [9:0] outer_global = global_counts[19:10];

    wire bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire bus_write = bus_req && wb_we_in;
    wire mem_sel = wb_adr_in[`MEM_WINDOW_BIT];
    wire [7:0] reg_ofs = wb_adr_in[7:0];
    // configuration is frozen while a payload is sent
    wire reg_write = bus_write && !mem_sel && !busy_out;
    wire mem_write = bus_write && mem_sel && !busy_out;
    wire start = reg_write && reg_ofs == `OFS_CONTROL && wb_sel_in[3] &&
        wb_dat_in[`CTL_START];

    function [31:0] merge;
        input [31:0] old_value;
        input [31:0] new_value;
        input [3:0] sel;
        integer i;
        begin
            merge = old_value;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = new_value[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] lc_wr = merge({7'h0, local_counts}, wb_dat_in, wb_sel_in);
    wire [31:0] gc_wr = merge({12'h0, global_counts}, wb_dat_in, wb_sel_in);
    wire [31:0] bd_wr = merge({18'h0, barrier_desc}, wb_dat_in, wb_sel_in);
    wire [31:0] ln_wr = merge({8'h0, lengths}, wb_dat_in, wb_sel_in);

    // unused loops are written as zero by software, so they enter as zero
    function [31:0] group_low;
        input [1:0] m;
        input [2:0] sel;
        begin
            if (m == `MODE_GROUPED) begin
                group_low = group_id;
            end else if (m != `MODE_WALKER) begin
                group_low = 32'h0;
            end else begin
                case (sel)
                    3'h1: group_low = {inner_global[6:0], outer_local,
                        mid_local, inner_local};
                    3'h2: group_low = {outer_global[6:0], inner_global,
                        outer_local, mid_local};
                    3'h3: group_low = {2'h0, outer_global, inner_global,
                        outer_local};
                    3'h4: group_low = {12'h0, outer_global,
                        inner_global};
                    default: group_low = 32'h0;
                endcase
            end
        end
    endfunction

    function [12:0] group_high;
        input [1:0] m;
        input [2:0] sel;
        begin
            if (m != `MODE_WALKER) begin
                group_high = 13'h0;
            end else begin
                case (sel)
                    3'h1: group_high = {outer_global,
                        inner_global[9:7]};
                    3'h2: group_high = {10'h0, outer_global[9:7]};
                    default: group_high = 13'h0;
                endcase
            end
        end
    endfunction

    function [31:0] header_dword;
        input [2:0] l;
        begin
            if (l == `LANE_GROUP_HIGH) begin
                header_dword = {control[`CTL_BARRIER_EN],
                    barrier_desc[6:0],
                    group_high(mode, loop_sel),
                    1'b0,
                    barrier_desc[13:8],
                    4'h0};
            end else if (l == `LANE_SAMPLER) begin
                header_dword = {sampler[31:5], 1'b0,
                    sampler[3:0]};
            end else if (l == `LANE_BINDING) begin
                header_dword = {binding[31:5], 5'h0};
            end else if (l == `LANE_SCRATCH) begin
                // pointer forced to zero unless scratch space is enabled
                header_dword = {control[`CTL_SCRATCH_EN] ? scratch[31:10] :
                    22'h0, scratch[9:0]};
            end else if (l == `LANE_GROUP_LOW) begin
                header_dword = group_low(mode, loop_sel);
            end else begin
                header_dword = 32'h0;
            end
        end
    endfunction

    // register bus
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            control <= `RST_WORD;
            local_counts <= 25'h0;
            global_counts <= 20'h0;
            group_id <= `RST_WORD;
            scratch <= `RST_WORD;
            binding <= `RST_WORD;
            sampler <= `RST_WORD;
            barrier_desc <= 14'h0;
            lengths <= 24'h0;
        end else if (reg_write) begin
            if (reg_ofs == `OFS_CONTROL) begin
                control <= merge(control, wb_dat_in, wb_sel_in) &
                    32'h0007_0173;
            end else if (reg_ofs == `OFS_LOCAL_COUNTS) begin
                local_counts <= lc_wr[24:0];
            end else if (reg_ofs == `OFS_GLOBAL_COUNTS) begin
                global_counts <= gc_wr[19:0];
            end else if (reg_ofs == `OFS_GROUP_ID) begin
                group_id <= merge(group_id, wb_dat_in, wb_sel_in);
            end else if (reg_ofs == `OFS_SCRATCH) begin
                scratch <= merge(scratch, wb_dat_in, wb_sel_in);
            end else if (reg_ofs == `OFS_BINDING) begin
                binding <= merge(binding, wb_dat_in, wb_sel_in) &
                    32'hffff_ffe0;
            end else if (reg_ofs == `OFS_SAMPLER) begin
                sampler <= merge(sampler, wb_dat_in, wb_sel_in) &
                    32'hffff_ffef;
            end else if (reg_ofs == `OFS_BARRIER_DESC) begin
                barrier_desc <= bd_wr[13:0];
            end else if (reg_ofs == `OFS_LENGTHS) begin
                lengths <= ln_wr[23:0];
            end
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= `RST_WORD;
        end else begin
            wb_ack_out <= bus_req;
            if (bus_req && !wb_we_in) begin
                if (mem_sel) begin
                    wb_dat_out <= 32'h0;
                end else if (reg_ofs == `OFS_CONTROL) begin
                    wb_dat_out <= control;
                end else if (reg_ofs == `OFS_STATUS) begin
                    wb_dat_out <= {payload_count, 15'h0, busy_out};
                end else if (reg_ofs == `OFS_LOCAL_COUNTS) begin
                    wb_dat_out <= {7'h0, local_counts};
                end else if (reg_ofs == `OFS_GLOBAL_COUNTS) begin
                    wb_dat_out <= {12'h0, global_counts};
                end else if (reg_ofs == `OFS_GROUP_ID) begin
                    wb_dat_out <= group_id;
                end else if (reg_ofs == `OFS_SCRATCH) begin
                    wb_dat_out <= scratch;
                end else if (reg_ofs == `OFS_BINDING) begin
                    wb_dat_out <= binding;
                end else if (reg_ofs == `OFS_SAMPLER) begin
                    wb_dat_out <= sampler;
                end else if (reg_ofs == `OFS_BARRIER_DESC) begin
                    wb_dat_out <= {18'h0, barrier_desc};
                end else if (reg_ofs == `OFS_LENGTHS) begin
                    wb_dat_out <= {8'h0, lengths};
                end else begin
                    wb_dat_out <= 32'h0;
                end
            end
        end
    end

    // payload sequencer
    always @* begin
        next_state = state;
        next_lane = lane;
        next_row = row;
        next_const_rows_done = const_rows_done;
        next_inline_index = inline_index;
        next_mem_addr = mem_addr;
        emit = 1'b0;
        emit_src = SRC_HEADER;
        emit_last = 1'b0;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_HEADER;
                    next_lane = 3'h0;
                    next_row = 8'h0;
                    next_const_rows_done = 8'h0;
                    next_inline_index = 8'h0;
                    next_mem_addr = {MEM_ADDR_WIDTH{1'b0}};
                end
            end
            ST_HEADER: begin
                emit = 1'b1;
                next_lane = lane + 3'h1;
                if (lane == `LANE_LAST) begin
                    next_row = row + 8'h1;
                    if (const_en && const_rows != 8'h0) begin
                        next_state = ST_CONST;
                    end else if (inline_en && inline_dwords != 8'h0) begin
                        next_state = ST_INLINE;
                    end else begin
                        next_state = ST_IDLE;
                        emit_last = 1'b1;
                    end
                end
            end
            ST_CONST: begin
                emit = 1'b1;
                emit_src = SRC_MEM;
                next_lane = lane + 3'h1;
                next_mem_addr = mem_addr + 1'b1;
                if (lane == `LANE_LAST) begin
                    next_row = row + 8'h1;
                    next_const_rows_done = const_rows_done + 8'h1;
                    if (const_rows_done + 8'h1 >= const_rows) begin
                        if (inline_en && inline_dwords != 8'h0) begin
                            next_state = ST_INLINE;
                        end else begin
                            next_state = ST_IDLE;
                            emit_last = 1'b1;
                        end
                    end
                end
            end
            ST_INLINE: begin
                emit = 1'b1;
                next_lane = lane + 3'h1;
                next_inline_index = inline_index + 8'h1;
                if (inline_index < inline_dwords) begin
                    emit_src = SRC_MEM;
                    next_mem_addr = mem_addr + 1'b1;
                end else begin
                    emit_src = SRC_ZERO;
                end
                // the payload stops after the inline rows, nothing indirect
                if (lane == `LANE_LAST) begin
                    next_row = row + 8'h1;
                    if (inline_index + 8'h1 >= inline_dwords) begin
                        next_state = ST_IDLE;
                        emit_last = 1'b1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
            lane <= 3'h0;
            row <= 8'h0;
            const_rows_done <= 8'h0;
            inline_index <= 8'h0;
            mem_addr <= {MEM_ADDR_WIDTH{1'b0}};
            stage_valid <= 1'b0;
            stage_src <= SRC_HEADER;
            stage_header <= `RST_WORD;
            stage_row <= 8'h0;
            stage_lane <= 3'h0;
            stage_last <= 1'b0;
        end else begin
            state <= next_state;
            lane <= next_lane;
            row <= next_row;
            const_rows_done <= next_const_rows_done;
            inline_index <= next_inline_index;
            mem_addr <= next_mem_addr;
            stage_valid <= emit;
            stage_src <= emit_src;
            stage_header <= header_dword(lane);
            stage_row <= row;
            stage_lane <= lane;
            stage_last <= emit_last;
        end
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dword_valid_out <= 1'b0;
            dword_data_out <= `RST_WORD;
            dword_row_out <= 8'h0;
            dword_lane_out <= 3'h0;
            payload_last_out <= 1'b0;
            busy_out <= 1'b0;
            payload_count <= 16'h0;
        end else begin
            dword_valid_out <= stage_valid;
            dword_row_out <= stage_row;
            dword_lane_out <= stage_lane;
            payload_last_out <= stage_valid && stage_last;
            if (!stage_valid || stage_src == SRC_ZERO) begin
                dword_data_out <= 32'h0;
            end else if (stage_src == SRC_MEM) begin
                dword_data_out <= mem_rdata;
            end else begin
                dword_data_out <= stage_header;
            end
            // busy covers the whole pipeline, so it drops with the last dword
            if (start) begin
                busy_out <= 1'b1;
            end else if (stage_valid && stage_last) begin
                busy_out <= 1'b0;
                payload_count <= payload_count + 16'h1;
            end
        end
    end

    payload_memory #(
        .ADDR_WIDTH(MEM_ADDR_WIDTH),
        .DATA_WIDTH(32)
    ) u_payload_memory (
        .clk_in(clk_in),
        .write_in(mem_write),
        .write_addr_in(wb_adr_in[MEM_ADDR_WIDTH+1:2]),
        .write_data_in(wb_dat_in),
        .read_addr_in(mem_addr),
        .read_data_out(mem_rdata)
    );
endmodule // media_thread_header_builder

/* File: header_builder_checker_assertions.sv */
`timescale 1ns/1ns
module header_builder_checker (
    input wire clk_in,
    input wire reset_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [8:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    input wire dword_valid_out,
    input wire [31:0] dword_data_out,
    input wire [7:0] dword_row_out,
    input wire [2:0] dword_lane_out,
    input wire payload_last_out,
    input wire busy_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    wire hdr = dword_valid_out && dword_row_out == 8'h00;
    wire req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    // start only counts while idle; a start during a payload is dropped
    wire start = req && wb_we_in && wb_adr_in == 9'h000 && wb_sel_in[3]
        && wb_dat_in[31] && !busy_out;
    a_ack_latency: assert property (req |=> wb_ack_out)
        else $error("ack did not follow request");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held too long");
    a_start_header: assert property (start |-> ##[2:4] (hdr
        && dword_lane_out == 3'h0)) else $error("header did not start");
    a_lane_step: assert property (dword_valid_out && dword_lane_out != 3'h7
        |=> dword_valid_out && dword_lane_out == $past(dword_lane_out) + 3'h1)
        else $error("lane sequence broken");
    a_row_step: assert property (dword_valid_out && dword_lane_out == 3'h7
        && !payload_last_out |=> dword_valid_out && dword_lane_out == 3'h0
        && dword_row_out == $past(dword_row_out) + 8'h01)
        else $error("row sequence broken");
    a_last_full_row: assert property (payload_last_out |-> dword_valid_out
        && dword_lane_out == 3'h7 ##1 !dword_valid_out)
        else $error("payload ended mid row");
    a_busy_release: assert property ($fell(busy_out) |-> payload_last_out)
        else $error("busy fell without last dword");
    a_unused_zero: assert property (hdr && (dword_lane_out < 3'h2
        || dword_lane_out == 3'h6) |-> dword_data_out == 32'h0000_0000)
        else $error("unlaid header dword not zero");
    a_group_resvd: assert property (hdr && dword_lane_out == 3'h2
        |-> !dword_data_out[10] && dword_data_out[3:0] == 4'h0)
        else $error("reserved dword 2 bits set");
    a_binding_low: assert property (hdr && dword_lane_out == 3'h4
        |-> dword_data_out[4:0] == 5'h00) else $error("binding low bits set");
    a_sampler_bit: assert property (hdr && dword_lane_out == 3'h3
        |-> !dword_data_out[4]) else $error("sampler bit 4 set");
    c_start: cover property (start);
    c_last: cover property (payload_last_out);
    c_header_only: cover property (hdr && payload_last_out);
endmodule // header_builder_checker
bind media_thread_header_builder header_builder_checker u_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .dword_valid_out(dword_valid_out),
    .dword_data_out(dword_data_out), .dword_row_out(dword_row_out),
    .dword_lane_out(dword_lane_out), .payload_last_out(payload_last_out),
    .busy_out(busy_out));

/* File: thread_register_sink.sv */
`timescale 1ns/1ns
// receiving register file: no back-pressure, so it just records
module thread_register_sink (
    input wire clk_in,
    input wire reset_n_in,
    input wire dword_valid_in,
    input wire [31:0] dword_data_in,
    input wire [7:0] row_in,
    input wire [2:0] lane_in,
    input wire last_in
);
    logic [31:0] got [0:63];
    int idx;
    int count;
    int bad;
    int payloads;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            idx <= 0;
            count <= 0;
            bad <= 0;
            payloads <= 0;
        end else if (dword_valid_in) begin
            if ({row_in, lane_in} != idx[10:0]) begin
                bad <= bad + 1;
            end
            got[idx[5:0]] <= dword_data_in;
            if (last_in) begin
                idx <= 0;
                count <= idx + 1;
                payloads <= payloads + 1;
            end else begin
                idx <= idx + 1;
            end
        end
    end
endmodule // thread_register_sink

/* File: tb_media_thread_header_builder.sv */
`timescale 1ns/1ns
module tb_media_thread_header_builder;
    logic clk_in = 0;
    logic reset_n_in = 0;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [8:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0;
    logic [31:0] rd;
    wire [31:0] wb_dat_out, dword_data_out;
    wire wb_ack_out, dword_valid_out, payload_last_out, busy_out;
    wire [7:0] dword_row_out;
    wire [2:0] dword_lane_out;
    int error_cnt = 0;
    int checks = 0;
    logic [31:0] mem [0:31];
    logic [31:0] exp_rows [0:63];
    always #50 clk_in = ~clk_in;
    media_thread_header_builder u_dut (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .dword_valid_out(dword_valid_out), .dword_data_out(dword_data_out),
        .dword_row_out(dword_row_out), .dword_lane_out(dword_lane_out),
        .payload_last_out(payload_last_out), .busy_out(busy_out));
    thread_register_sink u_sink (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .dword_valid_in(dword_valid_out), .dword_data_in(dword_data_out),
        .row_in(dword_row_out), .lane_in(dword_lane_out),
        .last_in(payload_last_out));
    task conclude;
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        t = 0;
        do begin
            @(posedge clk_in);
            t++;
        end while (wb_ack_out !== 1'b1 && t < 40);
        if (t >= 40)
            error_cnt++;
        rd = wb_dat_out;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic logic [31:0] grp_lo(input logic [1:0] m,
        input logic [2:0] s, input logic [31:0] lc, gc, gid);
        if (m == 2'h1)
            return gid;
        if (m != 2'h2)
            return 32'h0;
        case (s)
            3'h1: return {gc[6:0], lc[24:15], lc[14:10], lc[9:0]};
            3'h2: return {gc[16:10], gc[9:0], lc[24:15], lc[14:10]};
            3'h3: return {2'h0, gc[19:10], gc[9:0], lc[24:15]};
            3'h4: return {12'h000, gc[19:10], gc[9:0]};
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic [12:0] grp_hi(input logic [1:0] m,
        input logic [2:0] s, input logic [31:0] gc);
        if (m == 2'h2 && s == 3'h1)
            return {gc[19:10], gc[9:7]};
        if (m == 2'h2 && s == 3'h2)
            return {10'h000, gc[19:17]};
        return 13'h0;
    endfunction
    initial begin
        #(100 * 40000);
        error_cnt++;
        conclude;
    end
    initial begin
        logic [31:0] lc, gc, gid, scr, bnd, smp, bar, rb, ctl;
        logic [1:0] m;
        logic [2:0] s;
        int nc, ni, n, base, t;
        void'($urandom(30489));
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        // every mode against every loop selector
        for (int k = 0; k < 24; k++) begin
            m = 2'(k % 3);
            s = 3'(k / 3);
            lc = $urandom;
            gc = $urandom;
            gid = $urandom;
            scr = $urandom;
            bnd = $urandom;
            smp = $urandom;
            bar = $urandom;
            rb = $urandom;
            smp[3:0] = 4'($urandom % 12);
            bar[6] = 1'b0;
            nc = k == 0 ? 0 : $urandom % 3;
            ni = k == 0 ? 0 : (k == 1 ? 8 : $urandom % 12);
            for (int i = 0; i < 32; i++) begin
                mem[i] = $urandom;
                bus(1'b1, 9'h100 + 9'(i * 4), mem[i]);
            end
            bus(1'b1, 9'h008, lc);
            bus(1'b1, 9'h00c, gc);
            bus(1'b1, 9'h010, gid);
            bus(1'b1, 9'h014, scr);
            bus(1'b1, 9'h018, bnd);
            bus(1'b1, 9'h01c, smp);
            bus(1'b1, 9'h020, bar);
            bus(1'b1, 9'h024, {8'h00, 8'(ni), 8'h00, 8'(nc)});
            ctl = {1'b1, 12'h000, s, 7'h00, rb[0], 1'b0, rb[1], ni != 0,
                nc != 0, 2'h0, m};
            exp_rows[0] = 32'h0;
            exp_rows[1] = 32'h0;
            exp_rows[2] = {rb[0], bar[6:0], grp_hi(m, s, gc), 1'b0, bar[13:8],
                4'h0};
            exp_rows[3] = {smp[31:5], 1'b0, smp[3:0]};
            exp_rows[4] = {bnd[31:5], 5'h00};
            exp_rows[5] = {rb[1] ? scr[31:10] : 22'h0, scr[9:0]};
            exp_rows[6] = 32'h0;
            exp_rows[7] = grp_lo(m, s, lc, gc, gid);
            n = 8;
            for (int i = 0; i < nc * 8; i++)
                exp_rows[n++] = mem[i];
            for (int i = 0; i < (ni + 7) / 8 * 8; i++)
                exp_rows[n++] = i < ni ? mem[nc * 8 + i] : 32'h0;
            base = u_sink.payloads;
            bus(1'b1, 9'h000, ctl);
            if (k == 2) begin
                // both land while busy and must be dropped
                bus(1'b1, 9'h018, ~bnd);
                bus(1'b1, 9'h000, ctl);
            end
            t = 0;
            while (u_sink.payloads == base && t < 300) begin
                @(negedge clk_in);
                t++;
            end
            repeat (4) @(negedge clk_in);
            chk("payloads", base + 1, u_sink.payloads);
            chk("dword count", n, u_sink.count);
            chk("order", 0, u_sink.bad);
            for (int i = 0; i < 8; i++)
                chk("header", exp_rows[i], u_sink.got[i]);
            for (int i = 8; i < n; i++)
                chk("data row", exp_rows[i], u_sink.got[i]);
            bus(1'b0, 9'h018, 32'h0);
            chk("binding", {bnd[31:5], 5'h00}, rd);
            bus(1'b0, 9'h004, 32'h0);
            chk("status", {16'(k + 1), 16'h0000}, rd);
            bus(1'b0, 9'h030, 32'h0);
            chk("unmapped", 32'h0, rd);
            bus(1'b0, 9'h000, 32'h0);
            chk("start bit", 32'h0, {31'h0, rd[31]});
        end
        conclude;
    end
endmodule // tb_media_thread_header_builder
